// [rtl/pir_defines.svh]
`ifndef PIR_DEFINES_SVH
`define PIR_DEFINES_SVH

// check word generator
`define PIR_CRC_SEED      15'h0010
`define PIR_CRC_POLY      15'h4599

// register_control layout and reset value
`define PIR_CTL_RESET     8'h80
`define PIR_CTL_SRC_BIT   7
`define PIR_CTL_BROADCAST_READ_ENABLE_BIT 0

// command codes, low eleven bits of the command word
`define PIR_CC_READBACK   11'h004
`define PIR_CC_WR_PTR     11'h7e0
`define PIR_CC_WR_BURST   11'h7e1

// byte counts, written as last index
`define PIR_GROUP_LAST    3'd5
`define PIR_BURST_LAST    3'd3

// host serial clock timing
`define PIR_CLK_NS        10
`define PIR_SCK_HALF_NS   100

// host register offsets, byte addresses
`define PIR_A_CTRL        5'h00
`define PIR_A_CMD         5'h04
`define PIR_A_WDATA       5'h08
`define PIR_A_RDLO        5'h0c
`define PIR_A_RDHI        5'h10
`define PIR_A_ISTAT       5'h14
`define PIR_A_IMASK       5'h18

// host interrupt bits
`define PIR_IRQ_DONE      0
`define PIR_IRQ_PECERR    1

`endif

// [rtl/pir_pkg.sv]
`default_nettype none
package pir_pkg;
    typedef enum logic [2:0] {
        D_CMD, D_CPEC, D_WDATA, D_WPEC, D_TXD, D_TXP, D_IGN
    } pir_dev_st_type;

    typedef enum logic [2:0] {
        H_IDLE, H_CMD, H_CPEC, H_WDATA, H_WPEC, H_RDATA, H_RPEC, H_END
    } pir_host_st_type;

    typedef enum logic [1:0] {
        OP_READ, OP_WPTR, OP_WBURST
    } pir_op_type;
endpackage
`default_nettype wire

// [rtl/pir_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pir_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    modport host (output sclk, output cs_n, output mosi, input miso);
    modport device (input sclk, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

// [rtl/pir_crc15.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"
module pir_crc15 (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        init,
    input  wire logic        step,
    input  wire logic        din,
    // remainder
    output logic [14:0]      crc
);
    typedef struct packed {
        logic [14:0] crc;
    } pir_crc_st_type;

    pir_crc_st_type q, d;
    logic           fb;
    logic [14:0]    base;

    // one bit of the serial remainder update
    always_comb begin
        d     = q;
        base  = init ? `PIR_CRC_SEED : q.crc; // see RL9
        fb    = din ^ base[14]; // see RL11
        d.crc = base;
        if (step) begin
            // tap bits take feedback, the rest shift up  see RL10 see RL12
            d.crc = {base[13:0], 1'b0} ^ (`PIR_CRC_POLY & {15{fb}});
        end
    end

    // remainder register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.crc <= `PIR_CRC_SEED;
        end else begin
            q <= d;
        end
    end

    assign crc = q.crc;
endmodule
`default_nettype wire

// [rtl/pir_device.sv]
// Functional notes
// RL1 - source select set: answer with fast results
// RL2 - host clears select, sets enable, writes pointer
// RL3 - indirect bytes start at pointer, then next
// RL4 - pointer advances after every sent byte; here only after indirect data bytes, not check words or fast bytes
// RL5 - check word after every six data bytes
// RL6 - later only the pointer needs rewriting
// RL7 - burst writes pointer and control, skips two
// RL8 - last chain element read by readback commands
// RL9 - fifteen-bit check over group, seeded first
// RL10 - polynomial taps 15,14,10,8,7,4,3,0
// RL11 - feedback is input xor bit fourteen
// RL12 - tap bits load terms, others shift
// RL13 - check word is remainder shifted, zero lsb
// RL14 - received groups checked, accepted only on match
// RL15 - computed check word appended to sent group
// RL16 - high byte bits 14..7, low 6..0,0
// RL17 - host appends and verifies check words
// RL18 - host may use byte-wise table method
// RL19 - failed check changes nothing, await next
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"
module pir_device (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // serial link
    pir_if.device            link,
    // register readout port
    output logic [7:0]       reg_addr,
    input  wire logic [7:0]  reg_rdata,
    // fast conversion results
    input  wire logic [47:0] fast_data,
    input  wire logic [7:0]  fast_hs,
    // configuration and events
    output logic             readback_source_select,
    output logic             broadcast_read_enable,
    output logic             pec_error,
    output logic             cmd_accepted
);
    import pir_pkg::*;

    typedef struct packed {
        logic [2:0]     sy1;
        logic [2:0]     sy2;
        logic [2:0]     sy3;
        logic [1:0]     lvl;
        pir_dev_st_type st;
        logic [2:0]     bitc;
        logic [2:0]     gcnt;
        logic [15:0]    rx;
        logic [10:0]    cmd;
        logic [31:0]    wbuf;
        logic [2:0]     wlast;
        logic           wburst;
        logic           ind;
        logic           first;
        logic [7:0]     txsr;
        logic           miso;
        logic [7:0]     ptr;
        logic [7:0]     ctl;
        logic           pec_err;
        logic           cmd_ok;
    } pir_dev_type;

    pir_dev_type q, d;
    logic [14:0] crc;
    logic        crc_init;
    logic        crc_step;
    logic        crc_din;
    logic        sck_agree;
    logic        cs_agree;
    logic        rise;
    logic        fall;
    logic        cs_idle;
    logic        mosi_s;
    logic [7:0]  rx_byte;
    logic [15:0] rx_word;
    logic        chk_ok;
    logic [7:0]  tx_byte;

    pir_crc15 u_crc (
        .clk   (clk),
        .rst_n (rst_n),
        .init  (crc_init),
        .step  (crc_step),
        .din   (crc_din),
        .crc   (crc)
    );

    // edge finding on the synchronised link pins
    always_comb begin
        sck_agree = q.sy2[0] == q.sy3[0];
        cs_agree  = q.sy2[1] == q.sy3[1];
        rise      = sck_agree & q.sy3[0] & ~q.lvl[0];
        fall      = sck_agree & ~q.sy3[0] & q.lvl[0];
        cs_idle   = q.lvl[1];
        mosi_s    = q.sy3[2];
        rx_byte   = {q.rx[6:0], mosi_s};
        rx_word   = {q.rx[14:0], mosi_s};
        chk_ok    = rx_word == {crc, 1'b0}; // see RL13 see RL14
    end

    // byte to shift out next
    always_comb begin
        tx_byte = 8'h00;
        if (q.st == D_TXP) begin
            // see RL15 see RL16
            tx_byte = (q.gcnt == 3'd0) ? crc[14:7] : {crc[6:0], 1'b0};
        end else if (q.ind) begin
            tx_byte = reg_rdata; // see RL3
        end else if (q.first) begin
            tx_byte = fast_data[{q.gcnt, 3'b000} +: 8]; // see RL1
        end else begin
            tx_byte = fast_hs;
        end
    end

    // frame handling
    always_comb begin
        d          = q;
        d.sy1      = {link.mosi, link.cs_n, link.sclk};
        d.sy2      = q.sy1;
        d.sy3      = q.sy2;
        d.pec_err  = 1'b0;
        d.cmd_ok   = 1'b0;
        crc_init   = 1'b0;
        crc_step   = 1'b0;
        crc_din    = mosi_s;
        if (sck_agree) begin
            d.lvl[0] = q.sy3[0];
        end
        if (cs_agree) begin
            d.lvl[1] = q.sy3[1];
        end
        if (cs_idle) begin
            // deselected: restart at the command
            d.st     = D_CMD;
            d.bitc   = 3'd0;
            d.gcnt   = 3'd0;
            d.miso   = 1'b0;
            crc_init = 1'b1; // see RL9
        end else if (rise) begin
            d.rx     = rx_word;
            d.bitc   = q.bitc + 3'd1;
            crc_step = (q.st == D_CMD) || (q.st == D_WDATA); // see RL14
            if (q.bitc == 3'd7) begin
                unique case (q.st)
                    D_CMD: begin
                        d.gcnt = q.gcnt + 3'd1;
                        if (q.gcnt == 3'd1) begin
                            d.cmd  = rx_word[10:0];
                            d.gcnt = 3'd0;
                            d.st   = D_CPEC;
                        end
                    end
                    D_CPEC: begin
                        d.gcnt = 3'd1;
                        if (q.gcnt == 3'd1) begin
                            d.gcnt   = 3'd0;
                            crc_init = 1'b1;
                            d.st     = D_IGN;
                            if (!chk_ok) begin
                                d.pec_err = 1'b1; // see RL19
                            end else if (q.cmd == `PIR_CC_READBACK) begin
                                // see RL8
                                d.st     = D_TXD;
                                d.first  = 1'b1;
                                d.cmd_ok = 1'b1;
                                // see RL1 see RL2
                                d.ind    = ~q.ctl[`PIR_CTL_SRC_BIT] & q.ctl[`PIR_CTL_BROADCAST_READ_ENABLE_BIT];
                            end else if (q.cmd == `PIR_CC_WR_PTR) begin
                                d.st     = D_WDATA;
                                d.wlast  = 3'd0;
                                d.wburst = 1'b0;
                            end else if (q.cmd == `PIR_CC_WR_BURST) begin
                                d.st     = D_WDATA;
                                d.wlast  = `PIR_BURST_LAST;
                                d.wburst = 1'b1;
                            end
                        end
                    end
                    D_WDATA: begin
                        d.wbuf = {q.wbuf[23:0], rx_byte};
                        d.gcnt = q.gcnt + 3'd1;
                        if (q.gcnt == q.wlast) begin
                            d.gcnt = 3'd0;
                            d.st   = D_WPEC;
                        end
                    end
                    D_WPEC: begin
                        d.gcnt = 3'd1;
                        if (q.gcnt == 3'd1) begin
                            d.gcnt = 3'd0;
                            d.st   = D_IGN;
                            if (!chk_ok) begin
                                d.pec_err = 1'b1; // see RL19
                            end else begin
                                d.cmd_ok = 1'b1;
                                if (q.wburst) begin
                                    // middle two bytes dropped  see RL7
                                    d.ptr = q.wbuf[31:24];
                                    d.ctl = q.wbuf[7:0];
                                end else begin
                                    d.ptr = q.wbuf[7:0]; // see RL6
                                end
                            end
                        end
                    end
                    D_TXD: begin
                        if (q.ind) begin
                            d.ptr = q.ptr + 8'd1; // see RL4
                        end
                        d.gcnt = q.gcnt + 3'd1;
                        if (q.gcnt == `PIR_GROUP_LAST) begin
                            d.gcnt = 3'd0;
                            d.st   = D_TXP; // see RL5
                        end
                    end
                    D_TXP: begin
                        d.gcnt = 3'd1;
                        if (q.gcnt == 3'd1) begin
                            d.gcnt   = 3'd0;
                            d.first  = 1'b0;
                            d.st     = D_TXD;
                            crc_init = 1'b1; // see RL9
                        end
                    end
                    D_IGN: begin
                        d.gcnt = 3'd0;
                    end
                endcase
            end
        end else if (fall && (q.st == D_TXD || q.st == D_TXP)) begin
            // drive the next bit, msb first
            if (q.bitc == 3'd0) begin
                d.miso = tx_byte[7];
                d.txsr = {tx_byte[6:0], 1'b0};
            end else begin
                d.miso = q.txsr[7];
                d.txsr = {q.txsr[6:0], 1'b0};
            end
            crc_din  = d.miso;
            crc_step = q.st == D_TXD; // see RL9 see RL15
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.sy1    <= 3'h2;
            q.sy2    <= 3'h2;
            q.sy3    <= 3'h2;
            q.lvl    <= 2'h2;
            q.st     <= D_CMD;
            q.ctl    <= `PIR_CTL_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign link.miso              = q.miso;
    assign reg_addr               = q.ptr;
    assign readback_source_select = q.ctl[`PIR_CTL_SRC_BIT];
    assign broadcast_read_enable  = q.ctl[`PIR_CTL_BROADCAST_READ_ENABLE_BIT];
    assign pec_error              = q.pec_err;
    assign cmd_accepted           = q.cmd_ok;
endmodule
`default_nettype wire

// [rtl/pir_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"
module pir_host (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // interrupt
    output logic             irq,
    // serial link
    pir_if.host              link
);
    import pir_pkg::*;

    localparam int HALF = `PIR_SCK_HALF_NS / `PIR_CLK_NS;

    typedef struct packed {
        logic            ack;
        logic [31:0]     rdata;
        pir_host_st_type st;
        pir_op_type      op;
        logic [15:0]     cmd;
        logic [15:0]     wd;
        logic [47:0]     rd;
        logic [1:0]      istat;
        logic [1:0]      imask;
        logic [3:0]      div;
        logic            sclk;
        logic            cs_n;
        logic            mosi;
        logic [2:0]      bitc;
        logic [2:0]      idx;
        logic [7:0]      txsr;
        logic [15:0]     rsr;
        logic [2:0]      sy;
    } pir_host_type;

    pir_host_type q, d;
    logic [14:0] crc;
    logic        crc_init;
    logic        crc_step;
    logic        crc_din;
    logic        tick;
    logic        drv;
    logic        rbit;
    logic [7:0]  b;
    logic [1:0]  set_ev;
    logic [2:0]  wlast;

    pir_crc15 u_crc (
        .clk   (clk),
        .rst_n (rst_n),
        .init  (crc_init),
        .step  (crc_step),
        .din   (crc_din),
        .crc   (crc)
    );

    // frame sequencer and register slave
    always_comb begin
        d        = q;
        d.sy     = {q.sy[1:0], link.miso};
        crc_init = 1'b0;
        crc_step = 1'b0;
        crc_din  = 1'b0;
        drv      = 1'b0;
        set_ev   = 2'b00;
        b        = 8'h00;
        rbit     = q.sy[2];
        tick     = q.div == 4'(HALF - 1);
        wlast    = (q.op == OP_WBURST) ? `PIR_BURST_LAST : 3'd0;
        if (q.st != H_IDLE) begin
            d.div = tick ? 4'd0 : q.div + 4'd1;
        end
        if (q.st != H_IDLE && tick && !q.sclk) begin
            // rising edge: sample the device
            d.sclk = 1'b1;
            d.bitc = q.bitc + 3'd1;
            d.rsr  = {q.rsr[14:0], rbit};
            crc_din  = rbit;
            crc_step = q.st == H_RDATA; // see RL17
            if (q.bitc == 3'd7) begin
                d.idx = q.idx + 3'd1;
                unique case (q.st)
                    H_CMD: if (q.idx == 3'd1) begin
                        d.idx = 3'd0;
                        d.st  = H_CPEC;
                    end
                    H_CPEC: if (q.idx == 3'd1) begin
                        d.idx    = 3'd0;
                        crc_init = 1'b1;
                        d.st     = (q.op == OP_READ) ? H_RDATA : H_WDATA;
                    end
                    H_WDATA: if (q.idx == wlast) begin
                        d.idx = 3'd0;
                        d.st  = H_WPEC;
                    end
                    H_WPEC: if (q.idx == 3'd1) begin
                        d.st = H_END;
                    end
                    H_RDATA: begin
                        d.rd = {q.rd[39:0], q.rsr[6:0], rbit};
                        if (q.idx == `PIR_GROUP_LAST) begin
                            d.idx = 3'd0;
                            d.st  = H_RPEC;
                        end
                    end
                    H_RPEC: if (q.idx == 3'd1) begin
                        // see RL17
                        set_ev[`PIR_IRQ_PECERR] = {q.rsr[14:0], rbit} != {crc, 1'b0};
                        d.st = H_END;
                    end
                    default: d.idx = 3'd0;
                endcase
            end
        end else if (q.st != H_IDLE && tick) begin
            // falling edge: next bit or end of frame
            d.sclk = 1'b0;
            if (q.st == H_END) begin
                d.st   = H_IDLE;
                d.cs_n = 1'b1;
                d.mosi = 1'b0;
                set_ev[`PIR_IRQ_DONE] = 1'b1;
            end else begin
                drv = 1'b1;
            end
        end
        // register access on the acknowledge cycle
        d.ack = (avs_read | avs_write) & ~q.ack;
        if (q.ack && avs_write) begin
            unique case (avs_address)
                `PIR_A_CTRL: if (avs_writedata[0] && q.st == H_IDLE && avs_writedata[2:1] != 2'd3) begin
                    d.op     = pir_op_type'(avs_writedata[2:1]);
                    d.st     = H_CMD;
                    d.cs_n   = 1'b0;
                    d.div    = 4'd0;
                    d.bitc   = 3'd0;
                    d.idx    = 3'd0;
                    crc_init = 1'b1; // see RL9
                    drv      = 1'b1;
                end
                `PIR_A_CMD:   d.cmd   = avs_writedata[15:0];
                `PIR_A_WDATA: d.wd    = avs_writedata[15:0];
                `PIR_A_IMASK: d.imask = avs_writedata[1:0];
                default: ;
            endcase
        end
        // sticky status, set wins over write-one-to-clear
        d.istat = q.istat & ~((q.ack && avs_write && avs_address == `PIR_A_ISTAT) ?
                  avs_writedata[1:0] : 2'b00) | set_ev;
        // drive mosi, msb first; command and written data enter the check
        if (drv) begin
            unique case (d.st)
                H_CMD: b = (d.idx == 3'd0) ? q.cmd[15:8] : q.cmd[7:0];
                H_CPEC, H_WPEC: b = (d.idx == 3'd0) ? crc[14:7] : {crc[6:0], 1'b0}; // see RL16
                H_WDATA: begin
                    if (q.op == OP_WPTR || d.idx == 3'd0) begin
                        b = q.wd[7:0];
                    end else if (d.idx == `PIR_BURST_LAST) begin
                        b = q.wd[15:8];
                    end
                end
                default: b = 8'h00;
            endcase
            d.mosi   = (d.bitc == 3'd0) ? b[7] : q.txsr[7];
            d.txsr   = (d.bitc == 3'd0) ? {b[6:0], 1'b0} : {q.txsr[6:0], 1'b0};
            crc_din  = d.mosi;
            crc_step = (d.st == H_CMD) || (d.st == H_WDATA);
        end
        if (d.ack) begin
            unique case (avs_address)
                `PIR_A_CTRL:  d.rdata = {29'h0, q.op, q.st != H_IDLE};
                `PIR_A_CMD:   d.rdata = {16'h0, q.cmd};
                `PIR_A_WDATA: d.rdata = {16'h0, q.wd};
                `PIR_A_RDLO:  d.rdata = q.rd[31:0];
                `PIR_A_RDHI:  d.rdata = {16'h0, q.rd[47:32]};
                `PIR_A_ISTAT: d.rdata = {30'h0, q.istat};
                `PIR_A_IMASK: d.rdata = {30'h0, q.imask};
                default:      d.rdata = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q      <= '0;
            q.st   <= H_IDLE;
            q.op   <= OP_READ;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    assign irq             = |(q.istat & q.imask);
    assign link.sclk       = q.sclk;
    assign link.cs_n       = q.cs_n;
    assign link.mosi       = q.mosi;
endmodule
`default_nettype wire

// [tb/pir_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module pir_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    import pir_pkg::*;
    logic [7:0] nb_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // clock rises counted per frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nb_q <= 8'h00;
        end else if (cs_n) begin
            nb_q <= 8'h00;
        end else if ($rose(sclk)) begin
            nb_q <= nb_q + 8'h01;
        end
    end
    chk_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("link clock active outside frame");
    chk_first_rise: assert property ($fell(cs_n) |-> !sclk[*8] ##[1:4] sclk)
        else $error("first clock rise misplaced");
    chk_sclk_high: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*2] ##1 !sclk)
        else $error("clock high phase wrong");
    chk_sclk_low: assert property ($fell(sclk) |-> !sclk[*8] ##1 !sclk[*2])
        else $error("clock low phase short");
    chk_mosi_hold: assert property ($rose(sclk) && !cs_n |-> $stable(mosi)[*8])
        else $error("host data moved while clock high");
    chk_miso_hold: assert property ($rose(sclk) && !cs_n |-> $stable(miso)[*8])
        else $error("device data moved while clock high");
    chk_cs_gap: assert property ($rose(cs_n) |-> cs_n[*8] ##1 cs_n[*2])
        else $error("frame gap too short");
    chk_frame_bits: assert property ($rose(cs_n) |-> nb_q inside {8'h38, 8'h50, 8'h60})
        else $error("frame bit count wrong");
    cov_ptr_frame: cover property ($rose(cs_n) && nb_q == 8'h38);
    cov_burst_frame: cover property ($rose(cs_n) && nb_q == 8'h50);
    cov_read_frame: cover property ($rose(cs_n) && nb_q == 8'h60);
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"
module testbench;
    import pir_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_addr2;
    logic        sel, ben, pe1, pe2, ca2;
    logic [95:0] mo, mi, w;
    logic [31:0] q;
    logic [3:0]  pc1 = 4'h0, pc2 = 4'h0, cc2 = 4'h0;
    int          errors = 0, checks = 0, nb = 0;
    pir_if lk();
    pir_if lk2();
    pir_host u_pir_host (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .link(lk));
    pir_device u_pir_device (.clk(clk), .rst_n(rst_n), .link(lk), .reg_addr(reg_addr),
        .reg_rdata(reg_addr ^ 8'ha5), .fast_data(48'h665544332211), .fast_hs(8'h0f),
        .readback_source_select(sel), .broadcast_read_enable(ben), .pec_error(pe1),
        .cmd_accepted());
    pir_device u_pir_device_b (.clk(clk), .rst_n(rst_n), .link(lk2), .reg_addr(reg_addr2),
        .reg_rdata(8'h00), .fast_data(48'h0), .fast_hs(8'h00), .readback_source_select(),
        .broadcast_read_enable(), .pec_error(pe2), .cmd_accepted(ca2));
    pir_sva u_pir_sva (.clk(clk), .rst_n(rst_n), .sclk(lk.sclk), .cs_n(lk.cs_n),
        .mosi(lk.mosi), .miso(lk.miso));
    initial begin
        forever #5 clk = ~clk;
    end
    // event pulse tallies
    always @(posedge clk) begin
        if (pe1 === 1'b1) pc1 <= pc1 + 4'h1;
        if (pe2 === 1'b1) pc2 <= pc2 + 4'h1;
        if (ca2 === 1'b1) cc2 <= cc2 + 4'h1;
    end
    function automatic logic [15:0] pec(input logic [63:0] d, input int n);
        logic [14:0] c;
        logic        fb;
        c = `PIR_CRC_SEED;
        for (int i = n - 1; i >= 0; i--) begin
            fb = d[i] ^ c[14];
            c = {c[13:0], 1'b0} ^ (fb ? `PIR_CRC_POLY : 15'h0000);
        end
        return {c, 1'b0};
    endfunction
    function automatic logic [47:0] ind(input logic [7:0] p);
        logic [47:0] r;
        for (int k = 0; k < 6; k++) r = {r[39:0], (p + 8'(k)) ^ 8'ha5};
        return r;
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [47:0] g, input logic [47:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            end_of_test();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // start an operation, await done, check and clear status
    task automatic run(input logic [31:0] c, input logic ei);
        int n;
        n = 0;
        bus(1, `PIR_A_CMD, c[2] ? `PIR_CC_WR_BURST : c[1] ? `PIR_CC_WR_PTR : `PIR_CC_READBACK);
        bus(1, `PIR_A_CTRL, c);
        do begin
            bus(0, `PIR_A_ISTAT, 0);
            n++;
        end while (q[0] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            errors++;
            end_of_test();
        end
        cmp(q, 1);
        cmp(irq, ei);
        bus(1, `PIR_A_ISTAT, 3);
        bus(0, `PIR_A_ISTAT, 0);
        cmp({q, irq}, 0);
    endtask
    task automatic grp(input logic [47:0] e, input logic ei);
        logic [47:0] r;
        run(1, ei);
        bus(0, `PIR_A_RDLO, 0);
        r[31:0] = q;
        bus(0, `PIR_A_RDHI, 0);
        r[47:32] = q[15:0];
        cmp(r, e);
    endtask
    // bench-driven frame into the second device
    task automatic send(input logic [63:0] d, input int n);
        lk2.cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            lk2.mosi <= d[i];
            repeat (10) @(posedge clk);
            lk2.sclk <= 1'b1;
            repeat (10) @(posedge clk);
            lk2.sclk <= 1'b0;
        end
        lk2.cs_n <= 1'b1;
        lk2.mosi <= !d[0];
        repeat (20) @(posedge clk);
    endtask
    // wire capture of the first link
    always @(posedge lk.sclk) begin
        if (lk.cs_n === 1'b0) begin
            mo = {mo[94:0], lk.mosi};
            mi = {mi[94:0], lk.miso};
            nb++;
        end
    end
    always @(negedge lk.cs_n) nb = 0;
    always @(posedge lk.cs_n) begin
        if (nb > 0) begin
            w = mo >> (nb - 32);
            cmp(w[15:0], pec(w[31:16], 16));
            if (nb < 96) cmp(mo[15:0], pec(mo >> 16, nb - 48));
            else cmp(mi[15:0], pec(mi >> 16, 48));
        end
    end
    initial begin
        lk2.sclk = 1'b0;
        lk2.cs_n = 1'b1;
        lk2.mosi = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        cmp({sel, ben, reg_addr}, {2'b10, 8'h00});
        bus(0, 5'h1c, 0);
        cmp(q, 0);
        bus(1, `PIR_A_IMASK, 1);
        grp(48'h112233445566, 1);
        $display("test fast readback done");
        bus(1, `PIR_A_WDATA, 32'h01fd);
        run(32'h5, 1);
        cmp({sel, ben}, 2'b01);
        grp(ind(8'hfd), 1);
        cmp(reg_addr, 8'h03);
        $display("test indirect burst done");
        bus(1, `PIR_A_IMASK, 0);
        bus(1, `PIR_A_WDATA, 32'h40);
        run(32'h3, 0);
        grp(ind(8'h40), 0);
        cmp(reg_addr, 8'h46);
        $display("test pointer rewrite done");
        send({16'h07e0, pec(64'h07e0, 16), 8'h33, pec(64'h33, 8)} ^ 48'h1, 56);
        cmp({pc2, cc2, reg_addr2}, 16'h1000);
        send({16'h07e0, pec(64'h07e0, 16), 8'h33, pec(64'h33, 8)}, 56);
        cmp({pc2, cc2, reg_addr2, pc1}, 20'h11330);
        $display("test check word faults done");
        end_of_test();
    end
endmodule
`default_nettype wire
